// ==== core/acf_output_format.sv ====
// Output side of a 12-bit sampling converter: coding, overflow, latency,
// a two-entry output buffer, output disable and sleep/nap power modes.
// Assumes i_analog_code and i_sample_valid come from i_clk logic; the strap,
// output-disable and power-down pins are asynchronous and are synchronised.
//
// Notes on behaviour
// - Offset binary: zero gives 800, top gives fff, bottom gives 000.
// - Two's complement: offset binary word with its top bit inverted.
// - Overflow flag high beyond range, word clamped to the extreme code.
// - One code step is about 0.488 mV; codes rise monotonically.
// - Strap: gnd OB/off, third OB/on, two thirds 2C/on, supply 2C/off.
// - Output-disable high puts word and overflow flag in high impedance.
// - Power-down low: normal conversion every sample clock.
// - Power-down and disable high: sleep; data invalid milliseconds after.
// - Power-down high, disable low: nap; first 100 cycles after invalid.
// - In sleep and nap the word and overflow flag outputs are high impedance.
// - Stabiliser on: sample on rising edge only, falling edge ignored.
`timescale 1ns/10ps
`include "acf_consts.svh"
module acf_output_format #(
   parameter int LATENCY            = `ACF_PIPE_LATENCY,
   parameter int SLEEP_RECOVER_CLKS = `ACF_SLEEP_RECOVER_CLKS
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   input  wire logic signed [13:0]     i_analog_code,
   input  wire logic                   i_sample_valid,
   output logic                        o_sample_ready,
   input  wire logic [1:0]             i_mode_strap,
   input  wire logic                   i_output_disable_n,
   input  wire logic                   i_power_down_request,
   output logic [`ACF_WORD_W-1:0]      o_sample_word,
   output logic                        o_sample_word_oe,
   output logic                        o_range_overflow_flag,
   output logic                        o_range_overflow_flag_oe,
   output logic                        o_word_valid,
   input  wire logic                   i_word_ready,
   output logic                        o_dcs_enabled,
   output logic                        o_twos_complement,
   output logic                        o_reference_on,
   output logic                        o_data_settling
);
   // Counter must hold the longer of the two recovery spans, whichever it is
   localparam int REC_MAX = (SLEEP_RECOVER_CLKS > `ACF_NAP_RECOVER_CLKS) ?
                            SLEEP_RECOVER_CLKS : `ACF_NAP_RECOVER_CLKS;
   localparam int CNT_W = $clog2(REC_MAX + 1);
   localparam logic [CNT_W-1:0] NAP_CNT   = CNT_W'(`ACF_NAP_RECOVER_CLKS);
   localparam logic [CNT_W-1:0] SLEEP_CNT = CNT_W'(SLEEP_RECOVER_CLKS);

   logic [1:0]              strap_s1_r, strap_s2_r;
   logic                    oen_s1_r, oen_s2_r, pd_s1_r, pd_s2_r;
   acf_pkg::acf_strap_t     strap_w;
   acf_pkg::acf_power_t     pm_r, pm_nxt;
   logic [CNT_W-1:0]        settle_r;
   acf_pkg::acf_sample_t    conv_w;
   logic                    pipe_v_r [LATENCY];
   acf_pkg::acf_sample_t    pipe_d_r [LATENCY];
   acf_pkg::acf_sample_t    out_r, skid_r;
   logic                    out_v_r, skid_v_r;
   logic                    run_w, adv_w, accept_w, push_w, pop_w;
   logic [`ACF_WORD_W-1:0]  offs_w;

   // Two-flop synchronisers for the asynchronous pins
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         strap_s1_r <= 2'h0;
         strap_s2_r <= 2'h0;
         oen_s1_r   <= 1'b1;
         oen_s2_r   <= 1'b1;
         pd_s1_r    <= 1'b0;
         pd_s2_r    <= 1'b0;
      end else begin
         strap_s1_r <= i_mode_strap;
         strap_s2_r <= strap_s1_r;
         oen_s1_r   <= i_output_disable_n;
         oen_s2_r   <= oen_s1_r;
         pd_s1_r    <= i_power_down_request;
         pd_s2_r    <= pd_s1_r;
      end
   end

   // Four-level strap decode into format and stabiliser enable
   always_comb begin
      case (strap_s2_r)
         `ACF_STRAP_GND:       strap_w = '{acf_pkg::ACF_FMT_OFFSET, 1'b0};
         `ACF_STRAP_THIRD:     strap_w = '{acf_pkg::ACF_FMT_OFFSET, 1'b1};
         `ACF_STRAP_TWO_THIRD: strap_w = '{acf_pkg::ACF_FMT_TWOS, 1'b1};
         default:              strap_w = '{acf_pkg::ACF_FMT_TWOS, 1'b0};
      endcase
   end

   // All sampling is on the rising edge; the stabiliser state is reported
   assign o_dcs_enabled     = strap_w.dcs_on;
   assign o_twos_complement = (strap_w.fmt == acf_pkg::ACF_FMT_TWOS);

   // Power mode from power-down and output-disable
   always_comb begin
      case ({pd_s2_r, oen_s2_r})
         2'b11:   pm_nxt = acf_pkg::ACF_PM_SLEEP;
         2'b10:   pm_nxt = acf_pkg::ACF_PM_NAP;
         default: pm_nxt = acf_pkg::ACF_PM_RUN;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         pm_r <= acf_pkg::ACF_PM_RUN;
      else
         pm_r <= pm_nxt;
   end

   // Recovery window after leaving nap or sleep
   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         settle_r <= '0;
      else if (pm_r == acf_pkg::ACF_PM_SLEEP && pm_nxt == acf_pkg::ACF_PM_RUN)
         settle_r <= SLEEP_CNT;
      else if (pm_r == acf_pkg::ACF_PM_NAP && pm_nxt == acf_pkg::ACF_PM_RUN)
         settle_r <= NAP_CNT;
      else if (pm_r != acf_pkg::ACF_PM_RUN)
         settle_r <= '0;
      else if (settle_r != '0)
         settle_r <= settle_r - CNT_W'(1);
   end

   assign o_data_settling = (settle_r != '0);
   assign o_reference_on  = (pm_r != acf_pkg::ACF_PM_SLEEP);

   // Clamp, code and flag one conversion; one LSB is ACF_LSB_UV microvolts
   always_comb begin
      if (i_analog_code > `ACF_IN_MAX) begin
         offs_w     = `ACF_CODE_MAX;
         conv_w.ovf = 1'b1;
      end else if (i_analog_code < `ACF_IN_MIN) begin
         offs_w     = `ACF_CODE_MIN;
         conv_w.ovf = 1'b1;
      end else begin
         offs_w     = i_analog_code[11:0] ^ `ACF_SIGN_FLIP;
         conv_w.ovf = 1'b0;
      end
      if (strap_w.fmt == acf_pkg::ACF_FMT_TWOS)
         conv_w.word = offs_w ^ `ACF_SIGN_FLIP;
      else
         conv_w.word = offs_w;
   end

   // Pipeline advances only when the buffer can take its last stage
   assign run_w          = (pm_r == acf_pkg::ACF_PM_RUN);
   assign adv_w          = !skid_v_r;
   assign accept_w       = i_sample_valid && adv_w && run_w;
   assign o_sample_ready = adv_w && run_w;
   assign push_w         = adv_w && pipe_v_r[LATENCY-1];
   assign pop_w          = out_v_r && i_word_ready;

   // Fixed-latency pipeline carrying word and flag together
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !run_w) begin
         for (int k = 0; k < LATENCY; k++) begin
            pipe_v_r[k] <= 1'b0;
            pipe_d_r[k] <= '0;
         end
      end else if (adv_w) begin
         pipe_v_r[0] <= i_sample_valid;
         pipe_d_r[0] <= conv_w;
         for (int k = 1; k < LATENCY; k++) begin
            pipe_v_r[k] <= pipe_v_r[k-1];
            pipe_d_r[k] <= pipe_d_r[k-1];
         end
      end
   end

   // Two-entry output buffer: head register plus skid register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !run_w) begin
         out_v_r  <= 1'b0;
         skid_v_r <= 1'b0;
         out_r    <= '0;
         skid_r   <= '0;
      end else if (!out_v_r || pop_w) begin
         if (skid_v_r) begin
            out_r    <= skid_r;
            out_v_r  <= 1'b1;
            skid_v_r <= 1'b0;
         end else begin
            out_r   <= pipe_d_r[LATENCY-1];
            out_v_r <= push_w;
         end
      end else if (push_w) begin
         skid_r   <= pipe_d_r[LATENCY-1];
         skid_v_r <= 1'b1;
      end
   end

   // Outputs: data from flops, drivers off when disabled or powered down
   assign o_sample_word            = out_r.word;
   assign o_range_overflow_flag    = out_r.ovf;
   assign o_word_valid             = out_v_r;
   assign o_sample_word_oe         = !oen_s2_r && run_w;
   assign o_range_overflow_flag_oe = !oen_s2_r && run_w;

   // Checks on coding, drivers, power modes and latency
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   offset_mid_a: assert property (
      i_analog_code == 14'sh0000 && !o_twos_complement
      |-> conv_w.word == 12'h800 && !conv_w.ovf) else $error("zero not mid");
   twos_flip_a: assert property (
      o_twos_complement && !conv_w.ovf |-> conv_w.word == i_analog_code[11:0])
      else $error("twos code wrong");
   ovf_clamp_a: assert property (
      o_word_valid && o_range_overflow_flag
      |-> o_sample_word inside {12'hfff, 12'h000, 12'h7ff, 12'h800})
      else $error("overflow word not extreme");
   code_mono_a: assert property (
      i_analog_code >= -14'sh0800 && i_analog_code <= 14'sh07ff && !o_twos_complement
      |-> conv_w.word == i_analog_code[11:0] + 12'h800 && !conv_w.ovf)
      else $error("code step wrong");
   strap_dec_a: assert property (
      $stable(i_mode_strap)[*3]
      |-> o_dcs_enabled == ($past(i_mode_strap, 2) inside {2'h1, 2'h2})
      && o_twos_complement == $past(i_mode_strap[1], 2)) else $error("strap decode");
   hiz_dis_a: assert property (
      i_output_disable_n ##2 1 |-> !o_sample_word_oe && !o_range_overflow_flag_oe)
      else $error("driving while disabled");
   run_drive_a: assert property (
      !pd_s2_r && !oen_s2_r ##1 !pd_s2_r && !oen_s2_r
      |-> o_sample_word_oe && o_sample_ready == !skid_v_r) else $error("not running");
   sleep_rec_a: assert property (
      pm_r == acf_pkg::ACF_PM_SLEEP ##1 pm_r == acf_pkg::ACF_PM_RUN
      |-> o_data_settling && o_reference_on) else $error("sleep recovery");
   nap_rec_a: assert property (
      pm_r == acf_pkg::ACF_PM_NAP ##1 pm_r == acf_pkg::ACF_PM_RUN
      |-> o_data_settling[*8]) else $error("nap recovery short");
   pd_hiz_a: assert property (
      pm_r != acf_pkg::ACF_PM_RUN
      |-> !o_sample_word_oe && !o_range_overflow_flag_oe && !o_sample_ready)
      else $error("driving in power down");
   // Repeat count matches the default five pipeline stages
   lat_out_a: assert property (
      accept_w ##1 (run_w && !skid_v_r)[*5] |=> o_word_valid) else $error("latency lost");

   cv_ovf_c:   cover property (o_word_valid && o_range_overflow_flag && i_word_ready);
   cv_stall_c: cover property (skid_v_r && !i_word_ready ##1 i_word_ready);
   cv_nap_c:   cover property (pm_r == acf_pkg::ACF_PM_NAP ##1 pm_r == acf_pkg::ACF_PM_RUN);
endmodule

// ==== core/acf_consts.svh ====
// Constants for the converter output formatter: codes, strap levels, timing.
// Assumes inclusion by bare name from the package and the formatter module.
`ifndef ACF_CONSTS_SVH
`define ACF_CONSTS_SVH
`define ACF_WORD_W          12
`define ACF_CODE_MID        12'h800
`define ACF_CODE_MAX        12'hfff
`define ACF_CODE_MIN        12'h000
`define ACF_SIGN_FLIP       12'h800
`define ACF_IN_MAX          14'sh07ff
`define ACF_IN_MIN          -14'sh0800
`define ACF_LSB_UV          488
`define ACF_STRAP_GND       2'h0
`define ACF_STRAP_THIRD     2'h1
`define ACF_STRAP_TWO_THIRD 2'h2
`define ACF_STRAP_VDD       2'h3
`define ACF_CLK_HZ          25000000
`define ACF_NAP_RECOVER_CLKS 100
`define ACF_SLEEP_RECOVER_MS 3
`define ACF_SLEEP_RECOVER_CLKS (`ACF_SLEEP_RECOVER_MS * (`ACF_CLK_HZ / 1000))
`define ACF_PIPE_LATENCY    5
`endif

// ==== core/acf_pkg.sv ====
// Types shared by the converter output formatter.
// Assumes acf_consts.svh is on the include path.
`include "acf_consts.svh"
package acf_pkg;
   typedef enum logic {
      ACF_FMT_OFFSET = 1'b0,
      ACF_FMT_TWOS   = 1'b1
   } acf_format_t;

   typedef enum logic [1:0] {
      ACF_PM_RUN   = 2'b00,
      ACF_PM_NAP   = 2'b01,
      ACF_PM_SLEEP = 2'b10
   } acf_power_t;

   typedef struct packed {
      logic                   ovf;
      logic [`ACF_WORD_W-1:0] word;
   } acf_sample_t;

   typedef struct packed {
      acf_format_t fmt;
      logic        dcs_on;
   } acf_strap_t;
endpackage

// ==== test/acf_rx_model.sv ====
// Receiving logic model: paces ready and captures word and flag pairs.
// Assumes the formatter outputs change on the rising edge of i_clk.
`timescale 1ns/10ps
module acf_rx_model (
   input  wire logic                 i_clk,
   input  wire logic [1:0]           i_pace,
   input  wire logic                 i_word_valid,
   input  wire logic                 i_settling,
   input  wire acf_pkg::acf_sample_t i_sample,
   output logic                      o_ready = 1'b0
);
   logic [12:0] got_q[$];
   logic        tick_r = 1'b0;
   // Pace 0 is prompt, 1 stalls, 2 takes every other cycle
   always @(posedge i_clk) begin
      tick_r  <= ~tick_r;
      o_ready <= (i_pace == 2'h0) || (i_pace == 2'h2 && tick_r);
   end
   // Words offered while recovery runs are dropped
   always @(posedge i_clk) begin
      if (i_word_valid && o_ready && !i_settling) begin
         got_q.push_back(i_sample);
      end
   end
endmodule

// ==== test/acf_output_format_tb_top.sv ====
// Testbench for the converter output formatter and its receiver.
// Assumes a 25 MHz clock and a shortened sleep recovery count.
`timescale 1ns/10ps
module acf_output_format_tb_top;
   localparam int SLP = 20;
   logic                 i_clk = 1'b0;
   logic                 rst   = 1'b1;
   logic signed [13:0]   code  = 14'sh0;
   logic                 vld   = 1'b0;
   logic [1:0]           strap = 2'h0;
   logic                 dis_n = 1'b0;
   logic                 pd    = 1'b0;
   logic [1:0]           pace  = 2'h0;
   logic                 s_rdy, oe, f_oe, w_vld, w_rdy, dcs, twos, ref_on, settle;
   logic [11:0]          s_word;
   logic                 s_ovf;
   logic [12:0]          exp_q[$];
   int                   fail_count = 0;
   int                   total_checks = 0;
   acf_output_format #(.SLEEP_RECOVER_CLKS(SLP)) uut (
      .i_clk(i_clk), .i_sys_rst(rst), .i_analog_code(code), .i_sample_valid(vld),
      .o_sample_ready(s_rdy), .i_mode_strap(strap), .i_output_disable_n(dis_n),
      .i_power_down_request(pd), .o_sample_word(s_word), .o_sample_word_oe(oe),
      .o_range_overflow_flag(s_ovf), .o_range_overflow_flag_oe(f_oe),
      .o_word_valid(w_vld), .i_word_ready(w_rdy), .o_dcs_enabled(dcs),
      .o_twos_complement(twos), .o_reference_on(ref_on), .o_data_settling(settle));
   acf_rx_model rx (
      .i_clk(i_clk), .i_pace(pace), .i_word_valid(w_vld), .i_settling(settle),
      .i_sample({s_ovf, s_word}), .o_ready(w_rdy));
   // Compare and count
   task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string s);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // Expected pair: clamp, offset by mid code, flip top bit in two's complement
   task automatic push_exp(input int v);
      int c;
      c = v > 2047 ? 2047 : (v < -2048 ? -2048 : v);
      exp_q.push_back({v > 2047 || v < -2048, 12'(c + 2048) ^ {strap[1], 11'h0}});
   endtask
   // Offer one sample and hold it until taken
   task automatic send(input int v);
      push_exp(v);
      @(negedge i_clk);
      code = 14'(v);
      vld = 1'b1;
      while (s_rdy !== 1'b1) @(negedge i_clk);
      @(posedge i_clk);
   endtask
   // Wait for the receiver to catch up, then compare in order
   task automatic drain();
      @(negedge i_clk);
      vld = 1'b0;
      for (int n = 0; n < 200 && rx.got_q.size() < exp_q.size(); n++) @(negedge i_clk);
      chk(13'(rx.got_q.size()), 13'(exp_q.size()), "count");
      while (exp_q.size() > 0 && rx.got_q.size() > 0)
         chk(rx.got_q.pop_front(), exp_q.pop_front(), "word");
      exp_q.delete();
      rx.got_q.delete();
   endtask
   task automatic t_codes();
      int v[10] = '{0, 1, -1, 2047, 2046, -2047, -2048, 2048, -2049, 8191};
      for (int s = 0; s < 4; s++) begin
         strap = 2'(s);
         cyc(6);
         chk({11'h0, dcs, twos}, {11'h0, s == 1 || s == 2, strap[1]}, "strap");
         foreach (v[k]) send(v[k]);
         drain();
      end
   endtask
   // Receiver stalls until the buffer refuses, then drains slowly
   task automatic t_stall();
      pace = 2'h1;
      for (int k = 0; k < 14; k++) begin
         @(negedge i_clk);
         code = 14'(k * 300 - 2048);
         vld = 1'b1;
         if (s_rdy === 1'b1) push_exp(k * 300 - 2048);
      end
      chk({12'h0, s_rdy}, 13'h0, "refuse");
      pace = 2'h2;
      drain();
      pace = 2'h0;
   endtask
   // Outputs released for four cycles, then driven again
   task automatic t_disable();
      dis_n = 1'b1;
      cyc(4);
      chk({11'h0, oe, f_oe}, 13'h0, "hi-z");
      dis_n = 1'b0;
      cyc(4);
      chk({11'h0, oe, f_oe}, 13'h3, "drive");
   endtask
   // Nap when disable is low, sleep when it is high
   task automatic t_power(input logic sleep);
      dis_n = sleep;
      pd = 1'b1;
      cyc(5);
      chk({9'h0, oe, f_oe, s_rdy, ref_on}, {12'h0, !sleep}, "down");
      pd = 1'b0;
      dis_n = 1'b0;
      cyc(5);
      chk({12'h0, settle}, 13'h1, "settle");
      cyc(sleep ? SLP - 12 : 90);
      chk({12'h0, settle}, 13'h1, "settle");
      cyc(15);
      chk({12'h0, settle}, 13'h0, "settled");
      send(-5);
      drain();
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Clock
   initial forever #20 i_clk = ~i_clk;
   // Watchdog
   initial begin
      #(40 * 6000);
      fail_count++;
      complete_run();
   end
   // Main sequence
   initial begin
      cyc(5);
      rst = 1'b0;
      cyc(3);
      t_codes();
      t_stall();
      t_disable();
      t_power(1'b0);
      t_power(1'b1);
      complete_run();
   end
endmodule
